// [rtl/icdbi_pkg.sv]
/*
 * package of the image codec dual bus interface: widths, host register
 * indices, logical operation codes, reset timing counts.
 * assumes a single 10 MHz clock shared by both ends.
 */
package icdbi_pkg;
    localparam int ICDBI_HDATA_W = 16; // host data port width
    localparam int ICDBI_HADDR_W = 4; // host register address width
    localparam int ICDBI_IADDR_W = 24; // image memory address width
    localparam int ICDBI_ALOW_W = 8; // dedicated low address pins
    localparam int ICDBI_CLK_NS = 100; // clock period in ns
    localparam int ICDBI_RST_MIN_CYC = 7; // least reset high width, cycles
    localparam int ICDBI_IO_WAIT_NS = 200; // least wait after reset release
    localparam int ICDBI_IO_WAIT_CYC = (ICDBI_IO_WAIT_NS + ICDBI_CLK_NS - 1) / ICDBI_CLK_NS;
    // host register indices
    localparam logic [3:0] ICDBI_REG_DATA = 4'h0; // data word port
    localparam logic [3:0] ICDBI_REG_DATA_HI = 4'h1; // upper byte of data port
    localparam logic [3:0] ICDBI_REG_ADDR_LO = 4'h2; // image address bits 15:0
    localparam logic [3:0] ICDBI_REG_ADDR_HI = 4'h3; // image address bits 23:16
    localparam logic [3:0] ICDBI_REG_CTRL = 4'h4; // op, direction, byte org, go
    localparam logic [3:0] ICDBI_REG_OPND = 4'h5; // logical operand
    localparam logic [3:0] ICDBI_REG_STAT = 4'h6; // status
    // control field positions
    localparam int ICDBI_CTRL_OP_LSB = 0; // two bits of operation
    localparam int ICDBI_CTRL_DIR = 2; // 1: memory to host
    localparam int ICDBI_CTRL_BYTE = 3; // byte organised memory
    localparam int ICDBI_CTRL_GO = 4; // start one word move
    localparam logic [15:0] ICDBI_CTRL_RST = 16'h0000; // control reset value
    typedef enum logic [1:0] {
        ICDBI_OP_PASS = 2'b00,
        ICDBI_OP_AND = 2'b01,
        ICDBI_OP_OR = 2'b10,
        ICDBI_OP_XOR = 2'b11
    } icdbi_op_t;
endpackage

// [rtl/icdbi_if.sv]
/*
 * interface joining the host end and the device end of the codec bus
 * interface; resolves two-way and floatable wires from the output enables.
 * assumes the testbench instantiates it; the idle pull-ups are modelled here.
 */
`timescale 1ns/1ps
`default_nettype none
interface icdbi_if;
    import icdbi_pkg::*;
    logic host_sel_n; // chip select from host
    logic ext_xfer_ack_n; // external dma acknowledge
    logic ext_xfer_req_n; // device dma request
    logic [3:0] host_reg_addr; // register select
    logic host_read_n; // read strobe
    logic host_write_n; // write strobe
    logic upper_byte_sel_n; // upper byte enable
    logic [15:0] host_data_dev_o; // device drive on data bus
    logic host_data_dev_oe; // device drives data bus
    logic [15:0] host_data_hst_o; // host drive on data bus
    logic host_data_hst_oe; // host drives data bus
    logic [15:0] host_data_bus; // resolved data bus
    logic [7:0] img_addr_low; // low address pins
    logic [15:0] img_ad_o; // multiplexed address/data drive
    logic img_ad_oe; // device drives multiplexed pins
    logic [15:0] img_ad_mem_o; // memory read data drive
    logic img_ad_mem_oe; // memory drives multiplexed pins
    logic [15:0] img_ad; // resolved multiplexed pins
    logic img_bus_owned; // device is bus master
    logic img_addr_latch; // address strobe
    logic img_bus_request; // bus request
    logic img_bus_grant; // bus grant
    logic img_read_n_o; // read strobe drive
    logic img_write_n_o; // write strobe drive
    logic img_strobe_oe; // strobes driven
    logic img_read_n; // resolved read strobe, pulled up
    logic img_write_n; // resolved write strobe, pulled up
    logic img_ready; // memory ready, low inserts waits
    // wire resolution: pulled up when nobody drives
    assign host_data_bus = host_data_dev_oe ? host_data_dev_o : (host_data_hst_oe ? host_data_hst_o : 16'hFFFF);
    assign img_ad = img_ad_oe ? img_ad_o : (img_ad_mem_oe ? img_ad_mem_o : 16'hFFFF);
    assign img_read_n = img_strobe_oe ? img_read_n_o : 1'b1;
    assign img_write_n = img_strobe_oe ? img_write_n_o : 1'b1;
    modport device (
        input host_sel_n, ext_xfer_ack_n, host_reg_addr, host_read_n, host_write_n, upper_byte_sel_n,
        input host_data_bus, img_ad, img_bus_grant, img_ready,
        output ext_xfer_req_n, host_data_dev_o, host_data_dev_oe, img_addr_low, img_ad_o, img_ad_oe,
        output img_bus_owned, img_addr_latch, img_bus_request, img_read_n_o, img_write_n_o, img_strobe_oe
    );
    modport host (
        output host_sel_n, ext_xfer_ack_n, host_reg_addr, host_read_n, host_write_n, upper_byte_sel_n,
        output host_data_hst_o, host_data_hst_oe,
        input host_data_bus, ext_xfer_req_n
    );
endinterface
`default_nettype wire

// [rtl/icdbi_img_master.sv]
/*
 * image memory bus master: request, grant, address strobe, multiplexed
 * address then data, read or write strobe with ready wait states.
 * assumes grant and ready come from other logic and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module icdbi_img_master
    import icdbi_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic grant_i,
    input wire logic ready_i,
    input wire logic [15:0] ad_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic request_o,
    output logic owned_o,
    output logic latch_o,
    output logic [7:0] addr_low_o,
    output logic [15:0] ad_o,
    output logic ad_oe_o,
    output logic read_n_o,
    output logic write_n_o,
    output logic strobe_oe_o
);
    typedef enum logic [2:0] {
        ICDBI_M_IDLE = 3'b000,
        ICDBI_M_REQ = 3'b001,
        ICDBI_M_ADDR = 3'b010,
        ICDBI_M_STRB = 3'b011,
        ICDBI_M_DONE = 3'b100
    } icdbi_mst_t;
    icdbi_mst_t state; // cycle sequencer
    logic [1:0] grant_s; // grant synchroniser
    logic [1:0] ready_s; // ready synchroniser
    logic wr; // latched direction
    logic [23:0] addr; // latched address
    logic [15:0] wdata; // latched write data
    logic strobe_min; // first strobe cycle passed
    // synchronise external pins, only the second stage is read
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            grant_s <= 2'b00;
            ready_s <= 2'b11;
        end else begin
            grant_s <= {grant_s[0], grant_i};
            ready_s <= {ready_s[0], ready_i};
        end
    end
    // sequencer: resets as bus slave, neither driving nor requesting
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ICDBI_M_IDLE;
            strobe_min <= 1'b0;
        end else begin
            case (state)
                ICDBI_M_IDLE: begin
                    if (start_i) begin
                        state <= ICDBI_M_REQ;
                    end
                end
                ICDBI_M_REQ: begin
                    // wait for the arbiter
                    if (grant_s[1]) begin
                        state <= ICDBI_M_ADDR;
                    end
                end
                ICDBI_M_ADDR: begin
                    state <= ICDBI_M_STRB;
                    strobe_min <= 1'b0;
                end
                ICDBI_M_STRB: begin
                    // strobe lasts two cycles at least; ready low stretches it
                    strobe_min <= 1'b1;
                    if (strobe_min && ready_s[1]) begin
                        state <= ICDBI_M_DONE;
                    end
                end
                ICDBI_M_DONE: begin
                    state <= ICDBI_M_IDLE;
                end
                default: begin
                    state <= ICDBI_M_IDLE;
                end
            endcase
        end
    end
    // capture request fields when idle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr <= 1'b0;
            addr <= 24'h000000;
            wdata <= 16'h0000;
        end else if (state == ICDBI_M_IDLE && start_i) begin
            wr <= write_i;
            addr <= addr_i;
            wdata <= wdata_i;
        end
    end
    // read data is taken on the last strobe cycle, before the strobe rises
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (state == ICDBI_M_STRB && strobe_min && ready_s[1] && !wr) begin
            rdata_o <= ad_i;
        end
    end
    // request only while slave and a transfer waits
    assign request_o = (state == ICDBI_M_REQ);
    // ownership for the whole master tenure
    assign owned_o = (state == ICDBI_M_ADDR) || (state == ICDBI_M_STRB) || (state == ICDBI_M_DONE);
    // one address strobe per bus cycle
    assign latch_o = (state == ICDBI_M_ADDR);
    // low address on its own pins, upper address multiplexed with data
    assign addr_low_o = owned_o ? addr[7:0] : 8'h00;
    assign ad_o = (state == ICDBI_M_ADDR) ? addr[23:8] : wdata;
    assign ad_oe_o = (state == ICDBI_M_ADDR) || (wr && state == ICDBI_M_STRB);
    // strobes high while master, low during the access, floated as slave
    assign strobe_oe_o = owned_o;
    assign read_n_o = !(state == ICDBI_M_STRB && !wr);
    assign write_n_o = !(state == ICDBI_M_STRB && wr);
    assign done_o = (state == ICDBI_M_DONE);
endmodule
`default_nettype wire

// [rtl/icdbi_device.sv]
/*
 * device end: host register port, word mover with logical operation,
 * byte split of words for byte organised image memory, dma request.
 * assumes host strobes are asynchronous pins and are synchronised here.
 */
// Function
// - host access only while chip select low
// - dma acknowledge high during plain accesses
// - dma request low when data or space
// - four address bits select a register
// - sixteen-bit two-way host data port
// - host strobes low to read or write
// - byte or word from upper-select and bit0
// - low address pins, upper address multiplexed
// - ownership output held while bus master
// - address strobe pulse each bus cycle
// - request bus when transfer needed
// - arbiter grants with memory acknowledge high
// - read strobe high, low reading, floated slave
// - write strobe high, low writing, floated slave
// - ready low inserts wait states
// - reset held at least seven clocks
// - after reset bus slave, idle
// - host via I/O, memory via dma only
// - moves apply AND, OR or XOR; host upper-only or lower-only byte writes are stored without it
// - byte memory splits word into two accesses
`timescale 1ns/1ps
`default_nettype none
module icdbi_device
    import icdbi_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    icdbi_if.device bus,
    output logic busy_o,
    output logic [15:0] last_word_o
);
    logic [2:0] sel_s, rd_s, wr_s; // host pin synchronisers, two stages plus edge history
    logic [3:0] ra_s1, ra_s2; // address synchroniser
    logic ube_s1, ube_s2; // upper select synchroniser
    logic [15:0] wd_s1, wd_s2; // write data synchroniser
    logic [15:0] data_reg; // data word buffer
    logic data_full; // buffer holds unread data
    logic [23:0] img_addr; // image word address
    logic [15:0] ctrl; // control register
    logic [15:0] opnd; // logical operand
    logic [1:0] half; // byte access step, bit0 active
    logic m_start, m_done; // master handshake
    logic [15:0] m_rdata; // master read data
    logic [15:0] m_wdata; // byte or word for the master
    logic [23:0] m_addr; // address for the master
    logic wr_edge; // host write completed
    logic rd_edge; // host read completed
    logic [15:0] stat; // status word
    logic m_busy; // mover holds or asks for the image bus
    // apply the chosen logical operation during a move
    function automatic logic [15:0] apply_op(input logic [1:0] op, input logic [15:0] a, input logic [15:0] b);
        case (icdbi_op_t'(op))
            ICDBI_OP_AND: apply_op = a & b;
            ICDBI_OP_OR: apply_op = a | b;
            ICDBI_OP_XOR: apply_op = a ^ b;
            default: apply_op = a;
        endcase
    endfunction
    // synchronise the host pins for register logic; the data drive enable uses them raw
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_s <= 3'b111;
            rd_s <= 3'b111;
            wr_s <= 3'b111;
            ra_s1 <= 4'h0;
            ra_s2 <= 4'h0;
            ube_s1 <= 1'b1;
            ube_s2 <= 1'b1;
            wd_s1 <= 16'h0000;
            wd_s2 <= 16'h0000;
        end else begin
            sel_s <= {sel_s[1:0], bus.host_sel_n};
            rd_s <= {rd_s[1:0], bus.host_read_n};
            wr_s <= {wr_s[1:0], bus.host_write_n};
            ra_s1 <= bus.host_reg_addr;
            ra_s2 <= ra_s1;
            ube_s1 <= bus.upper_byte_sel_n;
            ube_s2 <= ube_s1;
            wd_s1 <= bus.host_data_bus;
            wd_s2 <= wd_s1;
        end
    end
    // access completes on strobe rise while selected; dma acknowledge is not looked at
    assign wr_edge = wr_s[1] && !wr_s[2] && !sel_s[2];
    assign rd_edge = rd_s[1] && !rd_s[2] && !sel_s[2];
    // register writes; whole words, upper select and bit0 not used here
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            img_addr <= 24'h000000;
            ctrl <= ICDBI_CTRL_RST;
            opnd <= 16'h0000;
        end else begin
            if (m_done && half != 2'b11) begin
                img_addr <= img_addr + 24'h000001; // advance after each word
                ctrl[ICDBI_CTRL_GO] <= 1'b0;
            end
            if (wr_edge) begin
                case (ra_s2)
                    ICDBI_REG_ADDR_LO: img_addr[15:0] <= wd_s2;
                    ICDBI_REG_ADDR_HI: img_addr[23:16] <= wd_s2[7:0];
                    ICDBI_REG_CTRL: ctrl <= wd_s2;
                    ICDBI_REG_OPND: opnd <= wd_s2;
                    default: ;
                endcase
            end
        end
    end
    // data buffer: host word or upper byte writes fill it, memory reads fill it, opposite side drains it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_reg <= 16'h0000;
            data_full <= 1'b0;
        end else if (m_done && !ctrl[ICDBI_CTRL_DIR] && half != 2'b11) begin
            data_full <= 1'b0; // word written out to memory
        end else if (m_done && ctrl[ICDBI_CTRL_DIR]) begin
            // read step: odd byte, even byte, or whole word
            if (!ctrl[ICDBI_CTRL_BYTE]) begin
                data_reg <= apply_op(ctrl[1:0], m_rdata, opnd);
                data_full <= 1'b1;
            end else if (half == 2'b11) begin
                data_reg[15:8] <= m_rdata[7:0];
            end else begin
                data_reg <= apply_op(ctrl[1:0], {data_reg[15:8], m_rdata[7:0]}, opnd);
                data_full <= 1'b1;
            end
        end else if (wr_edge && (ra_s2 == ICDBI_REG_DATA || ra_s2 == ICDBI_REG_DATA_HI)) begin
            if (!ube_s2 && !ra_s2[0]) begin
                data_reg <= apply_op(ctrl[1:0], wd_s2, opnd); // word write
                data_full <= 1'b1;
            end else if (!ube_s2) begin
                data_reg[15:8] <= wd_s2[15:8]; // upper byte only
                data_full <= 1'b1;
            end else begin
                data_reg[7:0] <= wd_s2[7:0]; // lower byte only
            end
        end else if (rd_edge && ra_s2 == ICDBI_REG_DATA) begin
            data_full <= 1'b0;
        end
    end
    // byte split step: 11 odd byte pending, 01 even byte pending
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half <= 2'b00;
        end else if (m_start && ctrl[ICDBI_CTRL_BYTE] && half == 2'b00) begin
            half <= 2'b11;
        end else if (m_done && half == 2'b11) begin
            half <= 2'b01;
        end else if (m_done) begin
            half <= 2'b00;
        end
    end
    // memory only through the internal master
    assign busy_o = ctrl[ICDBI_CTRL_GO];
    // a net, not a function: a continuous assign would not wake on what a function reads
    assign m_busy = bus.img_bus_request || bus.img_bus_owned;
    assign m_start = ctrl[ICDBI_CTRL_GO] && !m_busy && (ctrl[ICDBI_CTRL_DIR] ? !data_full : data_full);
    assign m_addr = ctrl[ICDBI_CTRL_BYTE] ? {img_addr[22:0], half != 2'b01} : img_addr;
    assign m_wdata = !ctrl[ICDBI_CTRL_BYTE] ? data_reg : (half == 2'b01 ? {8'h00, data_reg[7:0]} : {8'h00, data_reg[15:8]});
    icdbi_img_master icdbi_img_master_inst (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(m_start || (half == 2'b01 && !m_busy)),
        .write_i(!ctrl[ICDBI_CTRL_DIR]),
        .addr_i(m_addr),
        .wdata_i(m_wdata),
        .grant_i(bus.img_bus_grant),
        .ready_i(bus.img_ready),
        .ad_i(bus.img_ad),
        .done_o(m_done),
        .rdata_o(m_rdata),
        .request_o(bus.img_bus_request),
        .owned_o(bus.img_bus_owned),
        .latch_o(bus.img_addr_latch),
        .addr_low_o(bus.img_addr_low),
        .ad_o(bus.img_ad_o),
        .ad_oe_o(bus.img_ad_oe),
        .read_n_o(bus.img_read_n_o),
        .write_n_o(bus.img_write_n_o),
        .strobe_oe_o(bus.img_strobe_oe)
    );
    // dma request low while data readable or space writable
    assign bus.ext_xfer_req_n = ctrl[ICDBI_CTRL_GO] ? (ctrl[ICDBI_CTRL_DIR] ? !data_full : data_full) : 1'b1;
    assign stat = {13'h0000, half != 2'b00, m_busy, data_full};
    // read mux on the synchronised index, settled long before the strobe falls
    always_comb begin
        case (ra_s2)
            ICDBI_REG_DATA: bus.host_data_dev_o = data_reg;
            ICDBI_REG_DATA_HI: bus.host_data_dev_o = {8'h00, data_reg[15:8]};
            ICDBI_REG_ADDR_LO: bus.host_data_dev_o = img_addr[15:0];
            ICDBI_REG_ADDR_HI: bus.host_data_dev_o = {8'h00, img_addr[23:16]};
            ICDBI_REG_CTRL: bus.host_data_dev_o = ctrl;
            ICDBI_REG_OPND: bus.host_data_dev_o = opnd;
            ICDBI_REG_STAT: bus.host_data_dev_o = stat;
            default: bus.host_data_dev_o = 16'h0000;
        endcase
    end
    // drive only during a selected read, float otherwise
    assign bus.host_data_dev_oe = !bus.host_sel_n && !bus.host_read_n;
    assign last_word_o = data_reg;
endmodule
`default_nettype wire

// [rtl/icdbi_host.sv]
/*
 * host end: turns one user request into an I/O read or write cycle
 * with chip select, strobes, byte selection and data drive.
 * assumes the device samples pins through two flip-flops.
 */
`timescale 1ns/1ps
`default_nettype none
module icdbi_host
    import icdbi_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic write_i,
    input wire logic byte_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic ready_o,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic ext_xfer_req_n_o,
    icdbi_if.host bus
);
    typedef enum logic [1:0] {
        ICDBI_H_IDLE = 2'b00,
        ICDBI_H_SETUP = 2'b01,
        ICDBI_H_STRB = 2'b10,
        ICDBI_H_HOLD = 2'b11
    } icdbi_hst_t;
    icdbi_hst_t state; // cycle sequencer
    logic [2:0] cnt; // phase counter
    logic wr, bsel; // latched kind
    logic [3:0] addr; // latched address
    logic [15:0] wdata; // latched write data
    logic [1:0] ext_xfer_req_n_s; // request synchroniser
    // phases are four clocks so the device's two-stage sampler sees each level
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ICDBI_H_IDLE;
            cnt <= 3'h0;
        end else begin
            case (state)
                ICDBI_H_IDLE: begin
                    cnt <= 3'h0;
                    if (req_i) begin
                        state <= ICDBI_H_SETUP;
                    end
                end
                default: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == 3'h3) begin
                        cnt <= 3'h0;
                        state <= (state == ICDBI_H_HOLD) ? ICDBI_H_IDLE : icdbi_hst_t'(state + 2'b01);
                    end
                end
            endcase
        end
    end
    // latch request
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr <= 1'b0;
            bsel <= 1'b0;
            addr <= 4'h0;
            wdata <= 16'h0000;
        end else if (state == ICDBI_H_IDLE && req_i) begin
            wr <= write_i;
            bsel <= byte_i;
            addr <= addr_i;
            wdata <= wdata_i;
        end
    end
    // sample read data just before the strobe rises
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
            ext_xfer_req_n_s <= 2'b11;
        end else begin
            ext_xfer_req_n_s <= {ext_xfer_req_n_s[0], bus.ext_xfer_req_n};
            if (state == ICDBI_H_STRB && cnt == 3'h3 && !wr) begin
                rdata_o <= bus.host_data_bus;
            end
        end
    end
    // select low for the whole cycle plain access keeps ack high
    assign bus.host_sel_n = (state == ICDBI_H_IDLE);
    assign bus.ext_xfer_ack_n = 1'b1;
    assign bus.host_reg_addr = addr;
    // strobes low in the strobe phase
    assign bus.host_read_n = !(state == ICDBI_H_STRB && !wr);
    assign bus.host_write_n = !(state == ICDBI_H_STRB && wr);
    // byte write at even address uses upper select high; word, or byte at odd address, uses low
    assign bus.upper_byte_sel_n = bsel && !addr[0];
    assign bus.host_data_hst_o = wdata;
    assign bus.host_data_hst_oe = wr && state != ICDBI_H_IDLE;
    assign ready_o = (state == ICDBI_H_IDLE);
    assign done_o = (state == ICDBI_H_HOLD) && cnt == 3'h3;
    assign ext_xfer_req_n_o = !ext_xfer_req_n_s[1];
endmodule
`default_nettype wire

// [testbench/icdbi_asserts.sv]
/* checker of the codec bus interface wires, fed from the interface.
   assumes one clock and an active high reset. */
`timescale 1ns/1ps
`default_nettype none
module icdbi_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic host_sel_n,
    input wire logic host_read_n,
    input wire logic host_data_dev_oe,
    input wire logic img_bus_owned,
    input wire logic img_addr_latch,
    input wire logic img_bus_request,
    input wire logic img_read_n,
    input wire logic img_write_n,
    input wire logic img_strobe_oe,
    input wire logic img_ready
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ready low long enough to have passed the two sync flops
    sequence s_stall; (!img_ready)[*3] ##0 (!img_read_n || !img_write_n); endsequence
    sequence s_strobe; !img_read_n || !img_write_n; endsequence
    a_host_drive_gate: assert property (host_data_dev_oe |-> !host_sel_n && !host_read_n) else $error("bad drive");
    a_slave_float: assert property (!img_bus_owned |-> !img_strobe_oe) else $error("strobe driven");
    a_owned_drive: assert property (img_bus_owned |-> img_strobe_oe && !img_bus_request) else $error("owned");
    a_latch_first: assert property ($rose(img_bus_owned) |-> img_addr_latch && img_read_n && img_write_n) else $error("latch");
    a_latch_pulse: assert property (img_addr_latch |=> !img_addr_latch) else $error("latch long");
    a_read_width: assert property ($fell(img_read_n) |=> !img_read_n) else $error("read short");
    a_wait_stretch: assert property (s_stall |=> s_strobe) else $error("no wait");
    a_reset_slave: assert property ($fell(rst_i) |-> !img_bus_owned && !img_bus_request) else $error("reset");
endmodule
`default_nettype wire

// [testbench/tb_icdbi.sv]
/* bench: host end and device end joined through the interface.
   assumes the image memory is the small model below. */
`timescale 1ns/1ps
`default_nettype none
module tb_icdbi;
    import icdbi_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [15:0] wd = 16'h0000;
    logic rdy, dn, busy, dq;
    logic [15:0] rd, cw, lw;
    logic bt = 1'b0; // host byte write select
    logic [23:0] ca;
    logic [3:0] oc = 4'h0; // owned cycles, paces ready
    // write flag, index, data, read value: operand, pass/and/or/xor, memory write, word read, byte read
    logic [36:0] rows [21] = '{37'h1500FF0000, 37'h1400000000, 37'h1012340000, 37'h0000001234,
        37'h1400010000, 37'h1012340000, 37'h0000000034, 37'h1400020000, 37'h1012340000, 37'h00000012FF,
        37'h1400030000, 37'h1012340000, 37'h00000012CB, 37'h1256780000, 37'h1300120000, 37'h1400100000,
        37'h10BEEF0000, 37'h1400140000, 37'h000000A5C3, 37'h14001C0000, 37'h000000C3C3};
    int fail_count = 0;
    int n_checks = 0;
    icdbi_if bus();
    icdbi_host icdbi_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .write_i(wr), .byte_i(bt),
        .addr_i(adr), .wdata_i(wd), .ready_o(rdy), .done_o(dn), .rdata_o(rd), .ext_xfer_req_n_o(dq), .bus(bus));
    icdbi_device icdbi_device_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(bus), .busy_o(busy), .last_word_o(lw));
    icdbi_asserts icdbi_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_sel_n(bus.host_sel_n),
        .host_read_n(bus.host_read_n), .host_data_dev_oe(bus.host_data_dev_oe), .img_bus_owned(bus.img_bus_owned),
        .img_addr_latch(bus.img_addr_latch), .img_bus_request(bus.img_bus_request), .img_read_n(bus.img_read_n),
        .img_write_n(bus.img_write_n), .img_strobe_oe(bus.img_strobe_oe), .img_ready(bus.img_ready));
    assign bus.img_ad_mem_oe = !bus.img_read_n; // memory answers only while read strobe low
    assign bus.img_ad_mem_o = 16'hA5C3;
    initial forever #50 ref_clk_i = ~ref_clk_i;
    // memory side: grant follows request, ready low early in each tenure to force waits
    always @(posedge ref_clk_i) begin
        #1;
        bus.img_bus_grant <= bus.img_bus_request;
        oc <= bus.img_bus_owned ? oc + 4'h1 : 4'h0;
        bus.img_ready <= !(bus.img_bus_owned && oc < 4'h3);
        if (bus.img_addr_latch) ca <= {bus.img_ad, bus.img_addr_low};
        if (!bus.img_write_n) cw <= bus.img_ad;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? dn : (k == 1 ? busy : rdy);
    endfunction
    // bounded wait: a limit used up ends the run
    task automatic wt(input int k, input logic v);
        int i;
        for (i = 0; i < 99 && pick(k) !== v; i++) @(posedge ref_clk_i) #1;
        if (pick(k) !== v) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic hio(input logic w, input logic [3:0] a, input logic [15:0] d);
        wt(2, 1'b1);
        wr = w;
        adr = a;
        wd = d;
        req = 1'b1;
        @(posedge ref_clk_i) #1 req = 1'b0;
        wt(0, 1'b1);
    endtask
    initial begin
        repeat (ICDBI_RST_MIN_CYC) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        chk("idle", {11'h000, bus.img_bus_owned, bus.img_bus_request, bus.img_read_n, bus.img_write_n,
            bus.host_sel_n}, 16'h0007);
        repeat (ICDBI_IO_WAIT_CYC) @(posedge ref_clk_i) #1;
        // a data write is let through while go waits; all else waits for idle mover
        foreach (rows[j]) begin
            if (!(rows[j][36] && rows[j][35:32] == 4'h0)) wt(1, 1'b0);
            hio(rows[j][36], rows[j][35:32], rows[j][31:16]);
            if (!rows[j][36]) chk("rdata", rd, rows[j][15:0]);
        end
        // last latch was the even byte access of word 12567A
        chk("adr_hi", ca[23:8], 16'h24AC);
        chk("adr_lo", {8'h00, ca[7:0]}, 16'h00F4);
        chk("wdata", cw, 16'hBEEF);
        hio(1'b1, 4'h0, 16'h0055);
        hio(1'b1, 4'h4, 16'h0014);
        chk("ext_xfer_req_n_full", {15'h0000, bus.ext_xfer_req_n}, 16'h0000);
        repeat (2) @(posedge ref_clk_i) #1;
        chk("ext_xfer_req_n_o", {15'h0000, dq}, 16'h0001);
        hio(1'b0, 4'h0, 16'h0000);
        chk("rd55", rd, 16'h0055);
        chk("ext_xfer_req_n_empty", {15'h0000, bus.ext_xfer_req_n}, 16'h0001);
        // the read freed the buffer, so the mover fetches a word; then patch its low byte
        wt(1, 1'b0);
        bt = 1'b1;
        hio(1'b1, 4'h0, 16'h1166);
        chk("last_word", lw, 16'hA566);
        hio(1'b0, 4'h0, 16'h0000);
        chk("byte_lo", rd, 16'hA566);
        tally_and_finish();
    end
endmodule
`default_nettype wire
